/* core/osr_bank.sv */
// Guard-time, command-option and loopback-status bank with APB access.
//
// What this block does
// - Idle guard before and after escape sequence.
// - Gaps between escape characters limited by guard.
// - Guard register spans 0..255, resets to 50.
// - Zero guard disables all escape timing checks.
// - Options bit 1 enables echo, resets one.
// - Options bit 2 suppresses result codes, resets zero.
// - Options bit 3 selects word result codes.
// - Options bit 5 records last dial selector.
// - Tone selector means data, pulse means voice.
// - Options bit 7 originate; answer/dial update it.
// - Options bits 0, 4, 6 read zero.
// - Options register resets to 0xaa.
// - Status bit 0 shows local digital loop.
// - Status bit 2 shows local data loop.
// - Status bit 3 shows far-requested remote loop.
// - Status bit 4 shows local remote loop.
// - Status bits 5, 6 show self-test loops.
// - Status bits 1 and 7 read zero.
// - Only one loopback test at a time.
// - Terminate command clears status to zero, but a far-end rise in the same cycle sets bit 3 if status was already zero.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps

module osr_bank
    import osr_pkg::*;
#(
    parameter int TICK_CYCLES = OSR_TICK_CYC, // Cycles per 0.02 s unit.
    parameter logic [7:0] ESC_CHAR = 8'h2b // Escape character code.
) (
    input wire logic clk_in, // System clock, 50 MHz.
    input wire logic rst_n_in, // Asynchronous reset, active low.
    input wire logic psel_in, // APB select.
    input wire logic penable_in, // APB access phase.
    input wire logic pwrite_in, // APB direction, high for write.
    input wire logic [11:0] paddr_in, // APB byte address.
    input wire logic [31:0] pwdata_in, // APB write data.
    input wire logic [3:0] pstrb_in, // APB byte strobes.
    output logic pready_out, // APB ready.
    output logic pslverr_out, // APB error on unmapped address.
    output logic [31:0] prdata_out, // APB read data.
    input wire logic data_mode_in, // High while link carries data.
    input wire logic char_valid_in, // One-cycle pulse per character.
    input wire logic [7:0] char_in, // Character from the terminal.
    input wire logic answer_cmd_in, // Pulse: answer command seen.
    input wire logic dial_cmd_in, // Pulse: dial command seen.
    input wire logic dial_pulse_sel_in, // Dial selector, high for pulse.
    input wire logic remote_loop_req_in, // Far end asks for a loop.
    input wire logic test_done_in, // Pulse: local test time ran out.
    output logic escape_detect_out, // Pulse: escape sequence seen.
    output logic echo_en_out, // Echo command characters.
    output logic result_quiet_out, // Suppress result codes.
    output logic verbose_out, // Word-form result codes.
    output logic voice_call_out, // Dial request is a voice call.
    output logic originate_out, // Originate, low for answer.
    output logic [7:0] test_status_out // Live loopback status byte.
);

    ////////////////////////////////////////////////////////////////////////
    // State record and its next value.
    osr_state_t st_ff; // Every flip-flop of the bank.
    osr_state_t nxt_st; // Next value of the whole record.

    // Decoded bus terms, filled by the combinational process.
    logic acc; // Access phase present.
    logic done; // Access completes at this edge.
    logic wr_lane; // Completing write with byte lane 0 enabled.
    logic addr_hit; // Address is one of the mapped words.
    logic [7:0] rd_val; // Read mux output.
    logic [7:0] start_vec; // Status pattern a test command asks for.

    // Escape-timing terms.
    logic is_esc; // Incoming character is the escape code.
    logic guard_zero; // Guard value of zero turns timing off.
    logic pre_ok; // Idle time reached the guard.
    logic gap_ok; // Gap still within the guard.
    logic remote_rise; // Far end just asked for a loop.
    logic remote_fall; // Far end just dropped its loop.

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for bus slave, options, tests and escape.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.hit = 1'b0;
        start_vec = 8'h00;

        // Bus decode; one wait state keeps read data a clean register.
        acc = psel_in & penable_in;
        done = acc & st_ff.pready;
        wr_lane = done & pwrite_in & pstrb_in[0];
        addr_hit = (paddr_in == OSR_GUARD_ADDR) ||
                   (paddr_in == OSR_OPT_ADDR) ||
                   (paddr_in == OSR_STAT_ADDR) ||
                   (paddr_in == OSR_TCMD_ADDR);

        // Read mux; the command register reads as zero.
        case (paddr_in)
            OSR_GUARD_ADDR: begin
                rd_val = st_ff.guard;
            end
            OSR_OPT_ADDR: begin
                rd_val = st_ff.opt & OSR_OPT_MASK;
            end
            OSR_STAT_ADDR: begin
                rd_val = st_ff.stat & OSR_STAT_MASK;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase

        // Ready rises one cycle into the access phase and falls after.
        nxt_st.pready = acc & ~st_ff.pready;
        if (acc && !st_ff.pready) begin
            nxt_st.pslverr = ~addr_hit;
            nxt_st.prdata = {24'h000000, rd_val};
        end else begin
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata = 32'h0000_0000;
        end

        // Guard register takes any byte value.
        if (wr_lane && paddr_in == OSR_GUARD_ADDR) begin
            nxt_st.guard = pwdata_in[7:0];
        end

        // Software write of options; unused bits stay zero.
        if (wr_lane && paddr_in == OSR_OPT_ADDR) begin
            nxt_st.opt = pwdata_in[7:0] & OSR_OPT_MASK;
        end

        // Answer and dial commands come after the write, so they win.
        if (answer_cmd_in) begin
            nxt_st.opt[OSR_OPT_ORIG] = 1'b0;
        end
        if (dial_cmd_in) begin
            nxt_st.opt[OSR_OPT_ORIG] = 1'b1;
            nxt_st.opt[OSR_OPT_PULSE] = dial_pulse_sel_in;
        end

        // Local test time-out ends only locally started tests.
        if (test_done_in) begin
            nxt_st.stat = st_ff.stat & ~OSR_STAT_LOCAL;
        end

        // Far-end loop request tracked on its edges.
        remote_rise = remote_loop_req_in & ~st_ff.remote_q;
        remote_fall = ~remote_loop_req_in & st_ff.remote_q;
        nxt_st.remote_q = remote_loop_req_in;
        if (remote_rise && st_ff.stat == 8'h00) begin
            nxt_st.stat[OSR_ST_RREM] = 1'b1;
        end else if (remote_fall) begin
            nxt_st.stat[OSR_ST_RREM] = 1'b0;
        end

        // Pattern that each test command would start.
        case (pwdata_in[3:0])
            OSR_LOCAL_DIGITAL_LOOP_CMD_A,
            OSR_LOCAL_DIGITAL_LOOP_CMD_B: begin
                start_vec[OSR_ST_LDL] = 1'b1;
            end
            OSR_LOCAL_DATA_LOOP_CMD: begin
                start_vec[OSR_ST_LDATA] = 1'b1;
            end
            OSR_REMOTE_DIGITAL_LOOP_CMD: begin
                start_vec[OSR_ST_RDL] = 1'b1;
            end
            OSR_REMOTE_LOOP_SELFTEST_CMD: begin
                start_vec[OSR_ST_RST] = 1'b1;
            end
            OSR_LOCAL_LOOP_SELFTEST_CMD: begin
                start_vec[OSR_ST_LST] = 1'b1;
            end
            default: begin
                // Grant commands and unknown codes start nothing here.
                start_vec = 8'h00;
            end
        endcase

        // Test commands; a start is refused while any test runs.
        if (wr_lane && paddr_in == OSR_TCMD_ADDR) begin
            if (pwdata_in[3:0] == OSR_TEST_TERMINATE_CMD) begin
                // A far-end rise in the same cycle still wins its bit if no test was running.
                nxt_st.stat = 8'h00;
                nxt_st.stat[OSR_ST_RREM] = remote_rise && st_ff.stat == 8'h00;
            end else if (st_ff.stat == 8'h00 && !remote_rise) begin
                if (start_vec != 8'h00) begin
                    nxt_st.stat = start_vec;
                end
            end
        end

        // Unit timer restarts at every character, so idle counts from it.
        is_esc = char_in == ESC_CHAR;
        if (char_valid_in) begin
            nxt_st.tick = 20'h00000;
            nxt_st.idle = 9'h000;
        end else if (st_ff.tick == 20'(TICK_CYCLES - 1)) begin
            nxt_st.tick = 20'h00000;
            if (st_ff.idle != 9'h1ff) begin
                nxt_st.idle = st_ff.idle + 9'h001;
            end
        end else begin
            nxt_st.tick = st_ff.tick + 20'h00001;
        end

        // Timing tests; a nine-bit idle count keeps 255 apart from more.
        guard_zero = st_ff.guard == 8'h00;
        pre_ok = guard_zero || st_ff.idle >= {1'b0, st_ff.guard};
        gap_ok = guard_zero || st_ff.idle <= {1'b0, st_ff.guard};

        // Escape recogniser; it only listens while in data mode.
        case (st_ff.esc)
            OSR_ESC_IDLE: begin
                if (char_valid_in && is_esc && pre_ok) begin
                    nxt_st.esc = OSR_ESC_ONE;
                end
            end
            OSR_ESC_ONE: begin
                if (char_valid_in) begin
                    nxt_st.esc = (is_esc && gap_ok) ? OSR_ESC_TWO
                                                    : OSR_ESC_IDLE;
                end else if (!gap_ok) begin
                    nxt_st.esc = OSR_ESC_IDLE;
                end
            end
            OSR_ESC_TWO: begin
                if (char_valid_in) begin
                    if (is_esc && gap_ok && guard_zero) begin
                        nxt_st.esc = OSR_ESC_IDLE;
                        nxt_st.hit = 1'b1;
                    end else if (is_esc && gap_ok) begin
                        nxt_st.esc = OSR_ESC_THREE;
                    end else begin
                        nxt_st.esc = OSR_ESC_IDLE;
                    end
                end else if (!gap_ok) begin
                    nxt_st.esc = OSR_ESC_IDLE;
                end
            end
            OSR_ESC_THREE: begin
                // Any character inside the trailing guard spoils it.
                if (char_valid_in) begin
                    nxt_st.esc = OSR_ESC_IDLE;
                end else if (pre_ok) begin
                    nxt_st.esc = OSR_ESC_IDLE;
                    nxt_st.hit = 1'b1;
                end
            end
            default: begin
                nxt_st.esc = OSR_ESC_IDLE;
            end
        endcase
        if (!data_mode_in) begin
            nxt_st.esc = OSR_ESC_IDLE;
            nxt_st.hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The single register process; reset loads constants only.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= OSR_STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each taken straight from the state record.
    assign pready_out = st_ff.pready;
    assign pslverr_out = st_ff.pslverr;
    assign prdata_out = st_ff.prdata;
    assign escape_detect_out = st_ff.hit;
    assign echo_en_out = st_ff.opt[OSR_OPT_ECHO];
    assign result_quiet_out = st_ff.opt[OSR_OPT_QUIET];
    assign verbose_out = st_ff.opt[OSR_OPT_VERB];
    assign voice_call_out = st_ff.opt[OSR_OPT_PULSE];
    assign originate_out = st_ff.opt[OSR_OPT_ORIG];
    assign test_status_out = st_ff.stat;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the bank's own behaviour.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // A completing write to a given word.
    sequence s_wr_opt;
        psel_in && penable_in && pready_out && pwrite_in &&
        pstrb_in[0] && paddr_in == OSR_OPT_ADDR;
    endsequence

    sequence s_wr_tcmd;
        psel_in && penable_in && pready_out && pwrite_in &&
        pstrb_in[0] && paddr_in == OSR_TCMD_ADDR;
    endsequence

    // Three escape characters with no timing, back to back.
    sequence s_three_fast;
        (char_valid_in && is_esc && guard_zero &&
         st_ff.esc == OSR_ESC_TWO && data_mode_in);
    endsequence

    AST_APB_WAIT: assert property (
        acc && !pready_out |=> pready_out ##1 !pready_out)
        else $error("APB ready did not follow one wait state");

    AST_OPT_ZERO: assert property (
        (st_ff.opt & ~OSR_OPT_MASK) == 8'h00)
        else $error("Unused option bits became set");

    AST_STAT_ZERO: assert property (
        (test_status_out & ~OSR_STAT_MASK) == 8'h00)
        else $error("Unused status bits became set");

    AST_ONE_TEST: assert property (
        $onehot0(test_status_out))
        else $error("More than one loopback test is running");

    AST_TERMINATE: assert property (
        s_wr_tcmd ##0 pwdata_in[3:0] == OSR_TEST_TERMINATE_CMD ##0
        !remote_rise |=> test_status_out == 8'h00)
        else $error("Terminate did not clear test status");

    AST_DATA_LOOP: assert property (
        s_wr_tcmd ##0 pwdata_in[3:0] == OSR_LOCAL_DATA_LOOP_CMD ##0
        test_status_out == 8'h00 && !remote_rise && !test_done_in
        |=> test_status_out == 8'h04)
        else $error("Local data loop did not start");

    AST_ECHO_WRITE: assert property (
        s_wr_opt |=> echo_en_out == $past(pwdata_in[1]))
        else $error("Echo option did not take the written value");

    AST_ANSWER: assert property (
        answer_cmd_in && !dial_cmd_in |=> !originate_out)
        else $error("Answer command did not select answer mode");

    AST_DIAL_SEL: assert property (
        dial_cmd_in |=> originate_out &&
        voice_call_out == $past(dial_pulse_sel_in))
        else $error("Dial command did not record its selector");

    AST_ZERO_GUARD: assert property (
        s_three_fast |=> escape_detect_out ##1 !escape_detect_out)
        else $error("Untimed escape sequence was not recognised");

    AST_GAP_LONG: assert property (
        st_ff.esc == OSR_ESC_ONE && !gap_ok && !char_valid_in &&
        data_mode_in |=> st_ff.esc == OSR_ESC_IDLE)
        else $error("Escape sequence survived a long gap");

    AST_TRAIL_GUARD: assert property (
        escape_detect_out |-> $past(st_ff.esc) == OSR_ESC_THREE ||
        $past(guard_zero))
        else $error("Escape seen without its trailing guard");

endmodule : osr_bank

/* core/osr_pkg.sv */
// Shared constants, types and reset values of the option and status bank.
package osr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the APB slave.
    localparam logic [11:0] OSR_GUARD_ADDR = 12'h000;
    localparam logic [11:0] OSR_OPT_ADDR = 12'h004;
    localparam logic [11:0] OSR_STAT_ADDR = 12'h008;
    localparam logic [11:0] OSR_TCMD_ADDR = 12'h00c;

    // Reset values; the status byte follows its per-bit defaults of zero.
    localparam logic [7:0] OSR_GUARD_RST = 8'h32;
    localparam logic [7:0] OSR_OPT_RST = 8'haa;
    localparam logic [7:0] OSR_STAT_RST = 8'h00;

    // Field positions of the command-options byte and its writable mask.
    localparam int OSR_OPT_ECHO = 1;
    localparam int OSR_OPT_QUIET = 2;
    localparam int OSR_OPT_VERB = 3;
    localparam int OSR_OPT_PULSE = 5;
    localparam int OSR_OPT_ORIG = 7;
    localparam logic [7:0] OSR_OPT_MASK = 8'hae;

    // Field positions of the test-status byte and its used-bit masks.
    localparam int OSR_ST_LDL = 0;
    localparam int OSR_ST_LDATA = 2;
    localparam int OSR_ST_RREM = 3;
    localparam int OSR_ST_RDL = 4;
    localparam int OSR_ST_RST = 5;
    localparam int OSR_ST_LST = 6;
    localparam logic [7:0] OSR_STAT_MASK = 8'h7d;
    localparam logic [7:0] OSR_STAT_LOCAL = 8'h75;

    // Test command codes written to the command register.
    localparam logic [3:0] OSR_TEST_TERMINATE_CMD = 4'h0;
    localparam logic [3:0] OSR_LOCAL_DIGITAL_LOOP_CMD_A = 4'h1;
    localparam logic [3:0] OSR_LOCAL_DIGITAL_LOOP_CMD_B = 4'h2;
    localparam logic [3:0] OSR_LOCAL_DATA_LOOP_CMD = 4'h3;
    localparam logic [3:0] OSR_REMOTE_GRANT_CMD_A = 4'h4;
    localparam logic [3:0] OSR_REMOTE_GRANT_CMD_B = 4'h5;
    localparam logic [3:0] OSR_REMOTE_DIGITAL_LOOP_CMD = 4'h6;
    localparam logic [3:0] OSR_REMOTE_LOOP_SELFTEST_CMD = 4'h7;
    localparam logic [3:0] OSR_LOCAL_LOOP_SELFTEST_CMD = 4'h8;

    // Guard-time unit of 0.02 s in ns, clock period in ns, unit in cycles.
    localparam int OSR_UNIT_NS = 20000000;
    localparam int OSR_CLK_NS = 20;
    localparam int OSR_TICK_CYC = OSR_UNIT_NS / OSR_CLK_NS;

    // Escape recogniser states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        OSR_ESC_IDLE = 2'b00,
        OSR_ESC_ONE = 2'b01,
        OSR_ESC_TWO = 2'b11,
        OSR_ESC_THREE = 2'b10
    } osr_esc_t;

    // The whole state of the bank in one packed record.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] guard;
        logic [7:0] opt;
        logic [7:0] stat;
        logic remote_q;
        osr_esc_t esc;
        logic [19:0] tick;
        logic [8:0] idle;
        logic hit;
    } osr_state_t;

    localparam osr_state_t OSR_STATE_RST = '{
        pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
        guard: OSR_GUARD_RST, opt: OSR_OPT_RST, stat: OSR_STAT_RST,
        remote_q: 1'b0, esc: OSR_ESC_IDLE, tick: 20'h00000,
        idle: 9'h000, hit: 1'b0};

endpackage : osr_pkg

/* dv/osr_term_model.sv */
// Behavioural data terminal that types characters into the bank.
`timescale 1ns/100ps

module osr_term_model (
    input wire logic clk_in, // System clock.
    output logic data_mode_out, // High while the link is in data mode.
    output logic char_valid_out, // One-cycle strobe per character.
    output logic [7:0] char_out // Character code.
);
    ////////////////////////////////////////////////////////////////////////
    // Between characters the line shows the inverse of the last one, so the
    // bank cannot lean on a stale value the simulator happens to keep.
    initial begin
        data_mode_out = 1'b0;
        char_valid_out = 1'b0;
        char_out = 8'h00;
    end

    // Lets gap edges pass, then shows one character for one cycle.
    task automatic send_char(input logic [7:0] c, input int gap);
        repeat (gap) @(posedge clk_in);
        char_valid_out <= 1'b1;
        char_out <= c;
        @(posedge clk_in);
        char_valid_out <= 1'b0;
        char_out <= ~c;
    endtask : send_char

    // Enters or leaves data mode just after an edge.
    task automatic set_mode(input logic m);
        @(posedge clk_in);
        data_mode_out <= m;
    endtask : set_mode
endmodule : osr_term_model

/* dv/tb.sv */
// Self-checking bench of the option and status bank.
`timescale 1ns/100ps

module tb;
    import osr_pkg::*;
    localparam int TICK = 4; // Short guard unit keeps the run brief.
    logic clk_in;
    logic rst_n_in;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr;
    logic data_mode, char_valid;
    logic [7:0] char_b;
    logic answer, dial, sel, rreq, tdone, esc;
    logic echo, quiet, verb, voice, orig;
    logic [7:0] status;
    int checks = 0;
    int n_fail = 0;
    int esc_cnt = 0; // Escape pulses seen so far.

    ////////////////////////////////////////////////////////////////////////
    osr_bank #(.TICK_CYCLES(TICK)) u_dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .pready_out(pready), .pslverr_out(pslverr),
        .prdata_out(prdata), .data_mode_in(data_mode),
        .char_valid_in(char_valid), .char_in(char_b),
        .answer_cmd_in(answer), .dial_cmd_in(dial),
        .dial_pulse_sel_in(sel), .remote_loop_req_in(rreq),
        .test_done_in(tdone), .escape_detect_out(esc),
        .echo_en_out(echo), .result_quiet_out(quiet),
        .verbose_out(verb), .voice_call_out(voice),
        .originate_out(orig), .test_status_out(status));
    osr_term_model u_term (.clk_in(clk_in), .data_mode_out(data_mode),
        .char_valid_out(char_valid), .char_out(char_b));

    // Free-running 50 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Counts escape pulses; each one stands a single cycle.
    always @(posedge clk_in) begin
        if (esc === 1'b1) esc_cnt <= esc_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready under a bound, never a fixed count.
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic err);
        int i;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write, then step past the edge so the new value is visible.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        #1;
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
            input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : rd_chk

    task automatic opt_chk(input logic [4:0] exp);
        chk({27'h0, orig, voice, verb, quiet, echo}, {27'h0, exp});
    endtask : opt_chk

    // Answer or dial pulse, then wait until the option outputs settle.
    task automatic hw_cmd(input logic a, input logic d, input logic s);
        @(posedge clk_in);
        answer <= a;
        dial <= d;
        sel <= s;
        @(posedge clk_in);
        answer <= 1'b0;
        dial <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask : hw_cmd

    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        rd_chk(OSR_GUARD_ADDR, 32'h0000_0032, 1'b0);
        rd_chk(OSR_OPT_ADDR, 32'h0000_00aa, 1'b0);
        rd_chk(OSR_STAT_ADDR, 32'h0000_0000, 1'b0);
        opt_chk(5'b11101);
        rd_chk(12'h010, 32'h0000_0000, 1'b1);
    endtask : s_reset

    // Full and empty patterns show which option bits can be written.
    task automatic s_regs;
        wr(OSR_GUARD_ADDR, 32'h0000_00ff);
        rd_chk(OSR_GUARD_ADDR, 32'h0000_00ff, 1'b0);
        pstrb <= 4'he;
        wr(OSR_GUARD_ADDR, 32'h0000_0011);
        rd_chk(OSR_GUARD_ADDR, 32'h0000_00ff, 1'b0);
        pstrb <= 4'hf;
        wr(OSR_OPT_ADDR, 32'h0000_00ff);
        rd_chk(OSR_OPT_ADDR, 32'h0000_00ae, 1'b0);
        opt_chk(5'b11111);
        wr(OSR_OPT_ADDR, 32'h0000_0000);
        opt_chk(5'b00000);
        wr(OSR_STAT_ADDR, 32'h0000_00ff);
        rd_chk(OSR_STAT_ADDR, 32'h0000_0000, 1'b0);
        wr(OSR_OPT_ADDR, 32'h0000_00aa);
    endtask : s_regs

    task automatic s_calls;
        hw_cmd(1'b1, 1'b0, 1'b0);
        rd_chk(OSR_OPT_ADDR, 32'h0000_002a, 1'b0);
        hw_cmd(1'b0, 1'b1, 1'b1);
        opt_chk(5'b11101);
        hw_cmd(1'b0, 1'b1, 1'b0);
        rd_chk(OSR_OPT_ADDR, 32'h0000_008a, 1'b0);
    endtask : s_calls

    // Every test command; a second start is refused; stop both ways.
    task automatic s_tests;
        logic [3:0] code [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8};
        int bitn [6] = '{0, 0, 2, 4, 5, 6};
        for (int i = 0; i < 6; i++) begin
            wr(OSR_TCMD_ADDR, {28'h0, code[i]});
            chk({24'h0, status}, 32'h1 << bitn[i]);
            wr(OSR_TCMD_ADDR, (i == 2) ? 32'h1 : 32'h3);
            chk({24'h0, status}, 32'h1 << bitn[i]);
            if (i % 2 == 0) begin
                wr(OSR_TCMD_ADDR, 32'h0000_0000);
            end else begin
                @(posedge clk_in);
                tdone <= 1'b1;
                @(posedge clk_in);
                tdone <= 1'b0;
                @(posedge clk_in);
                #1;
            end
            rd_chk(OSR_STAT_ADDR, 32'h0000_0000, 1'b0);
        end
        wr(OSR_TCMD_ADDR, 32'h0000_0004);
        chk({24'h0, status}, 32'h0000_0000);
        wr(OSR_TCMD_ADDR, 32'h0000_0005);
        chk({24'h0, status}, 32'h0000_0000);
    endtask : s_tests

    task automatic s_remote;
        @(posedge clk_in);
        rreq <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        rd_chk(OSR_STAT_ADDR, 32'h0000_0008, 1'b0);
        wr(OSR_TCMD_ADDR, 32'h0000_0001);
        chk({24'h0, status}, 32'h0000_0008);
        wr(OSR_TCMD_ADDR, 32'h0000_0000);
        chk({24'h0, status}, 32'h0000_0000);
        @(posedge clk_in);
        rreq <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk({24'h0, status}, 32'h0000_0000);
    endtask : s_remote

    // Zero guard first, then two units: 8 cycles of idle around and between characters.
    task automatic s_escape;
        wr(OSR_GUARD_ADDR, 32'h0000_0000);
        u_term.set_mode(1'b1);
        repeat (3) u_term.send_char(8'h2b, 1);
        repeat (6) @(posedge clk_in);
        chk(esc_cnt, 1);
        wr(OSR_GUARD_ADDR, 32'h0000_0002);
        u_term.send_char(8'h2b, 40);
        repeat (2) u_term.send_char(8'h2b, 2);
        repeat (4) @(posedge clk_in);
        chk(esc_cnt, 1);
        repeat (40) @(posedge clk_in);
        chk(esc_cnt, 2);
        u_term.send_char(8'h2b, 40);
        u_term.send_char(8'h2b, 2);
        u_term.send_char(8'h2b, 30);
        repeat (40) @(posedge clk_in);
        chk(esc_cnt, 2);
        u_term.send_char(8'h41, 40);
        repeat (3) u_term.send_char(8'h2b, 2);
        repeat (40) @(posedge clk_in);
        chk(esc_cnt, 2);
        u_term.set_mode(1'b0);
    endtask : s_escape

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        answer = 1'b0;
        dial = 1'b0;
        sel = 1'b0;
        rreq = 1'b0;
        tdone = 1'b0;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        s_reset();
        s_regs();
        s_calls();
        s_tests();
        s_remote();
        s_escape();
        test_done();
    end
endmodule : tb
